// ==== logic/acr_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// Access-control and latency-reporting capability registers of one switch port.
module acr_regs #(
    parameter bit P_UPSTREAM_PORT = 1'b0
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output var  logic [31:0] o_prdata,
    output var  logic        o_pready,
    output var  logic        o_pslverr,
    output var  logic [6:0]  o_acs_enable,
    output var  logic [7:0]  o_egress_vector,
    output var  logic [9:0]  o_snoop_lat_value,
    output var  logic [2:0]  o_snoop_lat_scale,
    output var  logic [9:0]  o_nosnoop_lat_value,
    output var  logic [2:0]  o_nosnoop_lat_scale
);
    acr_bus_if bus ();

    logic        acs_on;
    logic        ltr_on;
    logic [31:0] acs_ctl_q;
    logic [31:0] egress_q;
    logic [31:0] lat_q;
    logic [31:0] acs_hdr;
    logic [31:0] ltr_hdr;
    logic [31:0] acs_cap;
    logic [31:0] rdata_c;
    logic        err_c;
    logic        hit_ctl;
    logic        hit_egr;
    logic        hit_lat;

    // Port role decides which of the two structures exists.
    assign acs_on = ~P_UPSTREAM_PORT;
    assign ltr_on = P_UPSTREAM_PORT;

    acr_apb_slave u_slave (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_psel     (i_psel),
        .i_penable  (i_penable),
        .i_pwrite   (i_pwrite),
        .i_paddr    (i_paddr),
        .i_pwdata   (i_pwdata),
        .i_pstrb    (i_pstrb),
        .o_prdata   (o_prdata),
        .o_pready   (o_pready),
        .o_pslverr  (o_pslverr),
        .bus        (bus)
    );

    // Write selects; an absent structure ignores writes entirely.
    assign hit_ctl = bus.wr & acs_on & (bus.addr[11:2] == acr_pkg::ACS_CTL_OFS[11:2]);
    assign hit_egr = bus.wr & acs_on & (bus.addr[11:2] == acr_pkg::EGRESS_OFS[11:2]);
    assign hit_lat = bus.wr & ltr_on & (bus.addr[11:2] == acr_pkg::LAT_OFS[11:2]);

    // Feature enables; the mask keeps capability and reserved bits out of storage.
    acr_wreg #(
        .P_WMASK (acr_pkg::ACS_CTL_WMASK),
        .P_RST   (acr_pkg::ACS_CTL_RST)
    ) u_acs_ctl (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_wr       (hit_ctl),
        .i_wmask    (bus.wmask),
        .i_wdata    (bus.wdata),
        .o_q        (acs_ctl_q)
    );

    // Egress blocking vector.
    acr_wreg #(
        .P_WMASK (acr_pkg::EGRESS_WMASK),
        .P_RST   (acr_pkg::EGRESS_RST)
    ) u_egress (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_wr       (hit_egr),
        .i_wmask    (bus.wmask),
        .i_wdata    (bus.wdata),
        .o_q        (egress_q)
    );

    // Snoop and no-snoop latency share one word.
    acr_wreg #(
        .P_WMASK (acr_pkg::LAT_WMASK),
        .P_RST   (acr_pkg::LAT_RST)
    ) u_latency (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_wr       (hit_lat),
        .i_wmask    (bus.wmask),
        .i_wdata    (bus.wdata),
        .o_q        (lat_q)
    );

    // Control outputs are plain slices of the storage flops.
    assign o_acs_enable        = acs_ctl_q[acr_pkg::ACS_EN_LSB +: 7];
    assign o_egress_vector     = egress_q[7:0];
    assign o_snoop_lat_value   = lat_q[acr_pkg::SNOOP_VAL_LSB +: 10];
    assign o_snoop_lat_scale   = lat_q[acr_pkg::SNOOP_SCL_LSB +: 3];
    assign o_nosnoop_lat_value = lat_q[acr_pkg::NOSNP_VAL_LSB +: 10];
    assign o_nosnoop_lat_scale = lat_q[acr_pkg::NOSNP_SCL_LSB +: 3];

    // Headers are constants, so no write can ever reach them.
    assign acs_hdr = {acr_pkg::NEXT_CAP_PTR, acr_pkg::CAP_VERSION,
                      acr_pkg::ACS_CAP_ID};
    assign ltr_hdr = {acr_pkg::NEXT_CAP_PTR, acr_pkg::CAP_VERSION,
                      acr_pkg::LTR_CAP_ID};
    // Bit seven is reserved and reads zero.
    assign acs_cap = {acs_ctl_q[31:16], acr_pkg::EGRESS_VEC_SIZE, 1'b0,
                      acr_pkg::ACS_CAP_BITS};

    // Read decode. Word offsets of an absent structure read zero without error,
    // as unimplemented configuration space does; only foreign offsets flag error.
    always_comb begin
        rdata_c = 32'h0000_0000;
        err_c   = 1'b0;
        unique case (bus.addr[11:2])
            acr_pkg::ACS_HDR_OFS[11:2]: rdata_c = acs_on ? acs_hdr : 32'h0000_0000;
            acr_pkg::ACS_CTL_OFS[11:2]: rdata_c = acs_on ? acs_cap : 32'h0000_0000;
            acr_pkg::EGRESS_OFS[11:2]:  rdata_c = acs_on ? egress_q : 32'h0000_0000;
            acr_pkg::LTR_HDR_OFS[11:2]: rdata_c = ltr_on ? ltr_hdr : 32'h0000_0000;
            acr_pkg::LAT_OFS[11:2]:     rdata_c = ltr_on ? lat_q : 32'h0000_0000;
            default:                    err_c   = 1'b1;
        endcase
    end

    assign bus.rdata = rdata_c;
    assign bus.err   = err_c;

    // Checks on the bus-visible behaviour, all in the core clock domain.
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    logic rd_setup;
    logic wr_done;
    logic addr_mapped;

    // Helpers naming the read setup cycle and the write commit edge.
    assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
    assign wr_done  = i_psel & i_penable & i_pwrite & o_pready;
    // Word offsets that the bank decodes; a foreign offset must answer with an error.
    assign addr_mapped = i_paddr[11:2] inside {acr_pkg::ACS_HDR_OFS[11:2],
                                               acr_pkg::ACS_CTL_OFS[11:2],
                                               acr_pkg::EGRESS_OFS[11:2],
                                               acr_pkg::LTR_HDR_OFS[11:2],
                                               acr_pkg::LAT_OFS[11:2]};

    a_acs_id_fixed: assert property (
        (rd_setup && i_paddr == acr_pkg::ACS_HDR_OFS && acs_on)
        |=> (o_prdata[15:0] == acr_pkg::ACS_CAP_ID) && o_pready)
        else $error("Access-control header identifier wrong.");

    a_cap_version_fixed: assert property (
        (rd_setup && (i_paddr == acr_pkg::ACS_HDR_OFS && acs_on
                      || i_paddr == acr_pkg::LTR_HDR_OFS && ltr_on))
        |=> o_prdata[19:16] == acr_pkg::CAP_VERSION)
        else $error("Capability version wrong.");

    a_next_ptr_fixed: assert property (
        (rd_setup && (i_paddr == acr_pkg::ACS_HDR_OFS && acs_on
                      || i_paddr == acr_pkg::LTR_HDR_OFS && ltr_on))
        |=> o_prdata[31:20] == acr_pkg::NEXT_CAP_PTR)
        else $error("Next capability pointer wrong.");

    a_acs_absent_up: assert property (
        (rd_setup && !acs_on && (i_paddr == acr_pkg::ACS_HDR_OFS
         || i_paddr == acr_pkg::ACS_CTL_OFS || i_paddr == acr_pkg::EGRESS_OFS))
        |=> o_prdata == 32'h0000_0000 && !o_pslverr)
        else $error("Access-control structure visible on upstream port.");

    a_ltr_absent_down: assert property (
        (rd_setup && !ltr_on
         && (i_paddr == acr_pkg::LTR_HDR_OFS || i_paddr == acr_pkg::LAT_OFS))
        |=> o_prdata == 32'h0000_0000 && !o_pslverr)
        else $error("Latency structure visible on downstream port.");

    a_ltr_id_fixed: assert property (
        (rd_setup && i_paddr == acr_pkg::LTR_HDR_OFS && ltr_on)
        |=> o_prdata[15:0] == acr_pkg::LTR_CAP_ID)
        else $error("Latency header identifier wrong.");

    a_cap_bits_read: assert property (
        (rd_setup && i_paddr == acr_pkg::ACS_CTL_OFS && acs_on)
        |=> o_prdata[7:0] == {1'b0, acr_pkg::ACS_CAP_BITS})
        else $error("Capability bits wrong.");

    a_vec_size_read: assert property (
        (rd_setup && i_paddr == acr_pkg::ACS_CTL_OFS && acs_on)
        |=> o_prdata[15:8] == acr_pkg::EGRESS_VEC_SIZE)
        else $error("Egress vector size wrong.");

    a_enable_write: assert property (
        (wr_done && acs_on && i_paddr == acr_pkg::ACS_CTL_OFS && i_pstrb[2])
        |=> o_acs_enable == $past(i_pwdata[22:16]))
        else $error("Enable bits did not take the written value.");

    a_enable_read_back: assert property (
        (rd_setup && i_paddr == acr_pkg::ACS_CTL_OFS && acs_on)
        |=> o_prdata[22:16] == $past(o_acs_enable))
        else $error("Enable bits read back wrong.");

    a_egress_write: assert property (
        (wr_done && acs_on && i_paddr == acr_pkg::EGRESS_OFS && i_pstrb[0])
        ##1 (!wr_done)
        |-> o_egress_vector == $past(i_pwdata[7:0], 2))
        else $error("Egress vector did not take the written value.");

    a_snoop_write: assert property (
        (wr_done && ltr_on && i_paddr == acr_pkg::LAT_OFS && i_pstrb[1:0] == 2'h3)
        |=> {o_snoop_lat_scale, o_snoop_lat_value} == $past(i_pwdata[12:0]))
        else $error("Snoop latency did not take the written value.");

    a_nosnoop_write: assert property (
        (wr_done && ltr_on && i_paddr == acr_pkg::LAT_OFS && i_pstrb[3:2] == 2'h3)
        |=> {o_nosnoop_lat_scale, o_nosnoop_lat_value} == $past(i_pwdata[28:16]))
        else $error("No-snoop latency did not take the written value.");

    a_rsvd_zero: assert property (
        rd_setup |=> (o_prdata & ~(acr_pkg::ACS_CTL_WMASK | 32'h0000_FFFF)) == 0
                     || $past(i_paddr) != acr_pkg::ACS_CTL_OFS)
        else $error("Reserved bits of the capability word read nonzero.");

    a_rsvd_lat_zero: assert property (
        (rd_setup && i_paddr == acr_pkg::LAT_OFS)
        |=> (o_prdata & ~acr_pkg::LAT_WMASK) == 32'h0000_0000)
        else $error("Reserved latency bits read nonzero.");

    a_no_stray_write: assert property (
        (!wr_done) |=> $stable(o_egress_vector) && $stable(o_acs_enable)
                       && $stable(lat_q))
        else $error("Register changed without a committed write.");

    a_ready_one_cycle: assert property (
        (i_psel && !i_penable) |=> o_pready ##1 !o_pready || (i_psel && !i_penable))
        else $error("Ready did not follow the setup cycle.");

    // Stored fields read back whole, since software relies on read-modify-write.
    a_egress_read_back: assert property (
        (rd_setup && i_paddr == acr_pkg::EGRESS_OFS && acs_on)
        |=> o_prdata == {24'h00_0000, $past(o_egress_vector)})
        else $error("Egress vector read back wrong.");

    a_lat_read_back: assert property (
        (rd_setup && i_paddr == acr_pkg::LAT_OFS && ltr_on)
        |=> o_prdata == {3'h0, $past(o_nosnoop_lat_scale), $past(o_nosnoop_lat_value),
                         3'h0, $past(o_snoop_lat_scale), $past(o_snoop_lat_value)})
        else $error("Latency word read back wrong.");

    a_unmapped_err: assert property (
        (i_psel && !i_penable && !addr_mapped)
        |=> o_pslverr && o_prdata == 32'h0000_0000)
        else $error("Foreign offset did not answer with an error.");

    a_mapped_no_err: assert property (
        (i_psel && !i_penable && addr_mapped)
        |=> !o_pslverr)
        else $error("Decoded offset answered with an error.");

    a_write_reads_zero: assert property (
        (i_psel && !i_penable && i_pwrite)
        |=> o_prdata == 32'h0000_0000)
        else $error("Read data not zero during a write.");

    a_rdata_hold: assert property (
        (!(i_psel && !i_penable))
        |=> $stable(o_prdata) && $stable(o_pslverr))
        else $error("Answer changed outside a setup cycle.");

    a_acs_quiet_up: assert property (
        (!acs_on)
        |-> o_acs_enable == 7'h00 && o_egress_vector == 8'h00)
        else $error("Access-control fields set on upstream port.");

    a_ltr_quiet_down: assert property (
        (!ltr_on)
        |-> lat_q == 32'h0000_0000)
        else $error("Latency fields set on downstream port.");

    a_enable_keep: assert property (
        (wr_done && i_paddr == acr_pkg::ACS_CTL_OFS && !i_pstrb[2])
        |=> $stable(o_acs_enable))
        else $error("Enable bits changed without their byte strobe.");

    a_egress_keep: assert property (
        (wr_done && i_paddr == acr_pkg::EGRESS_OFS && !i_pstrb[0])
        |=> $stable(o_egress_vector))
        else $error("Egress vector changed without its byte strobe.");

    a_hdr_write_inert: assert property (
        (wr_done && (i_paddr == acr_pkg::ACS_HDR_OFS || i_paddr == acr_pkg::LTR_HDR_OFS))
        |=> $stable(o_acs_enable) && $stable(o_egress_vector) && $stable(lat_q))
        else $error("A header write altered stored fields.");
endmodule
`default_nettype wire

// ==== logic/acr_pkg.sv ====
// Functional notes
// - Access-control header low sixteen bits read the fixed capability identifier.
// - Both headers read a fixed capability version in bits 19:16.
// - Both headers hold a read-only next pointer in bits 31:20.
// - Access-control structure exists only on downstream ports.
// - Latency-reporting structure exists only on the upstream port.
// - Latency-reporting header low sixteen bits read its fixed identifier.
// - Capability bits zero to six read one; bit seven reads zero.
// - Bits 15:8 report egress vector size, fixed at eight.
// - Bits 16 to 22 are feature enables, cleared at reset.
// - Egress vector is eight writable bits, cleared at reset.
// - Snoop latency value 9:0 and scale 12:10 are writable, reset zero.
// - No-snoop latency value 25:16 and scale 28:26 are writable, reset zero.
`default_nettype none
package acr_pkg;
    // Register offsets within configuration space.
    localparam logic [11:0] ACS_HDR_OFS     = 12'h220;
    localparam logic [11:0] ACS_CTL_OFS     = 12'h224;
    localparam logic [11:0] EGRESS_OFS      = 12'h228;
    localparam logic [11:0] LTR_HDR_OFS     = 12'h230;
    localparam logic [11:0] LAT_OFS         = 12'h234;
    // Fixed header contents.
    localparam logic [15:0] ACS_CAP_ID      = 16'h000D;
    localparam logic [15:0] LTR_CAP_ID      = 16'h0018;
    localparam logic [3:0]  CAP_VERSION     = 4'h1;
    localparam logic [11:0] NEXT_CAP_PTR    = 12'h240;
    // Fixed capability contents.
    localparam logic [6:0]  ACS_CAP_BITS    = 7'h7F;
    localparam logic [7:0]  EGRESS_VEC_SIZE = 8'h08;
    // Field positions.
    localparam int          ACS_EN_LSB      = 16;
    localparam int          SNOOP_VAL_LSB   = 0;
    localparam int          SNOOP_SCL_LSB   = 10;
    localparam int          NOSNP_VAL_LSB   = 16;
    localparam int          NOSNP_SCL_LSB   = 26;
    // Writable bit masks and reset values.
    localparam logic [31:0] ACS_CTL_WMASK   = 32'h007F_0000;
    localparam logic [31:0] EGRESS_WMASK    = 32'h0000_00FF;
    localparam logic [31:0] LAT_WMASK       = 32'h1FFF_1FFF;
    localparam logic [31:0] ACS_CTL_RST     = 32'h0000_0000;
    localparam logic [31:0] EGRESS_RST      = 32'h0000_0000;
    localparam logic [31:0] LAT_RST         = 32'h0000_0000;
endpackage
`default_nettype wire

// ==== logic/acr_bus_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Decoded register access passed from the bus slave to the register bank.
interface acr_bus_if;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] wmask;
    logic [31:0] rdata;
    logic        err;
    modport slv (output wr, output addr, output wdata, output wmask,
                 input rdata, input err);
    modport regs (input wr, input addr, input wdata, input wmask,
                  output rdata, output err);
endinterface
`default_nettype wire

// ==== logic/acr_wreg.sv ====
`timescale 1ns/1ps
`default_nettype none
// One 32-bit register whose writable bits are set by a mask; the rest stay zero.
module acr_wreg #(
    parameter logic [31:0] P_WMASK = 32'hFFFF_FFFF,
    parameter logic [31:0] P_RST   = 32'h0000_0000
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_wr,
    input  wire logic [31:0] i_wmask,
    input  wire logic [31:0] i_wdata,
    output var  logic [31:0] o_q
);
    logic [31:0] keep;

    // Only bits that are both strobed and writable may change.
    assign keep = i_wmask & P_WMASK;

    // Storage updates only on a committed write.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_q <= P_RST & P_WMASK;
        end else if (i_wr) begin
            o_q <= (o_q & ~keep) | (i_wdata & keep);
        end
    end
endmodule
`default_nettype wire

// ==== logic/acr_apb_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
// APB slave with one wait-free access phase; all answers come from flops.
module acr_apb_slave (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output var  logic [31:0] o_prdata,
    output var  logic        o_pready,
    output var  logic        o_pslverr,
    acr_bus_if.slv           bus
);
    logic setup;

    // A setup cycle is where the answer is prepared for the next edge.
    assign setup = i_psel & ~i_penable;

    // Writes commit only on the edge that completes the access phase.
    assign bus.wr    = i_psel & i_penable & i_pwrite & o_pready;
    assign bus.addr  = i_paddr;
    assign bus.wdata = i_pwdata;
    assign bus.wmask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}},
                        {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

    // Ready rises in the access phase and falls after it is sampled.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= setup;
        end
    end

    // Read data and error are captured in setup and held through access.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (setup) begin
            o_prdata  <= i_pwrite ? 32'h0000_0000 : bus.rdata;
            o_pslverr <= bus.err;
        end
    end
endmodule
`default_nettype wire

// ==== sim/acs_ltr_ext_cap_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_ltr_ext_cap_regs_bench;
    logic        core_clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] dn_rdata, up_rdata;
    logic        dn_ready, up_ready, dn_err, up_err;
    logic [6:0]  dn_en, up_en;
    logic [7:0]  dn_egr, up_egr;
    logic [9:0]  dn_sv, up_sv, dn_nv, up_nv;
    logic [2:0]  dn_ss, up_ss, dn_ns, up_ns;
    logic [6:0]  m_en;
    logic [7:0]  m_egr;
    logic [31:0] m_lat;
    int          err_count;
    int          compares;
    int          seed;
    logic [11:0] tab [9] = '{12'h220, 12'h224, 12'h228, 12'h230, 12'h234,
                             12'h22C, 12'h238, 12'h200, 12'h23C};

    // Both port roles share one bus, so every access also checks the absent structure.
    acr_regs #(.P_UPSTREAM_PORT(1'b0)) dut_u (
        .i_core_clk(core_clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_prdata(dn_rdata), .o_pready(dn_ready), .o_pslverr(dn_err),
        .o_acs_enable(dn_en), .o_egress_vector(dn_egr),
        .o_snoop_lat_value(dn_sv), .o_snoop_lat_scale(dn_ss),
        .o_nosnoop_lat_value(dn_nv), .o_nosnoop_lat_scale(dn_ns));
    acr_regs #(.P_UPSTREAM_PORT(1'b1)) dut_u_up (
        .i_core_clk(core_clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .o_prdata(up_rdata), .o_pready(up_ready), .o_pslverr(up_err),
        .o_acs_enable(up_en), .o_egress_vector(up_egr),
        .o_snoop_lat_value(up_sv), .o_snoop_lat_scale(up_ss),
        .o_nosnoop_lat_value(up_nv), .o_nosnoop_lat_scale(up_ns));

    // The clock toggles every half period of 5 ns.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Expected read data of one port role, built from the bench's own copy of the fields.
    function automatic logic [31:0] exp_rd(input bit up, input logic [11:0] a);
        case ({a[11:2], 2'b00})
            12'h220: return up ? 32'h0 : 32'h2401_000D;
            12'h224: return up ? 32'h0 : {9'h0, m_en, 8'h08, 1'b0, 7'h7F};
            12'h228: return up ? 32'h0 : {24'h0, m_egr};
            12'h230: return up ? 32'h2401_0018 : 32'h0;
            12'h234: return up ? m_lat : 32'h0;
            default: return 32'h0;
        endcase
    endfunction

    // Only the five capability words are decoded; anything else answers with an error.
    function automatic logic exp_err(input logic [11:0] a);
        return !({a[11:2], 2'b00} inside {12'h220, 12'h224, 12'h228, 12'h230, 12'h234});
    endfunction

    // Compare one value and count it.
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic close_out();
        $display("Counts: %0d mismatches in %0d comparisons", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Control outputs must mirror the stored fields; the absent structure stays at zero.
    task automatic check_outs();
        chk({dn_en, dn_egr}, {m_en, m_egr}, "dn ctl");
        chk({dn_ns, dn_nv, dn_ss, dn_sv}, 26'h0, "dn lat");
        chk({up_en, up_egr}, 15'h0, "up ctl");
        chk({up_ns, up_nv, up_ss, up_sv}, {m_lat[28:16], m_lat[12:0]}, "up lat");
    endtask

    // One APB transfer, entered just after a rising edge; the caller releases or chains.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int          n;
        logic [31:0] m;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge core_clk);
        check_outs();
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (dn_ready !== 1'b1 && n < 20);
        if (dn_ready !== 1'b1) begin
            err_count++;
            close_out();
        end
        chk(up_ready, 1'b1, "up ready");
        chk({dn_err, up_err}, {2{exp_err(a)}}, "slave error");
        if (!wr) begin
            chk(dn_rdata, exp_rd(1'b0, a), "dn rd");
            chk(up_rdata, exp_rd(1'b1, a), "up rd");
        end
        // Writes land at this edge; only strobed bytes of writable bits may change.
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & d;
        if (wr && a == 12'h224 && s[2]) m_en = d[22:16];
        if (wr && a == 12'h228) m_egr = (m_egr & ~{8{s[0]}}) | m[7:0];
        if (wr && a == 12'h234) begin
            m_lat = (m_lat & ~({{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & 32'h1FFF_1FFF))
                  | (m & 32'h1FFF_1FFF);
        end
    endtask

    // Drop the bus for one cycle and look at the control outputs.
    task automatic idle();
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
        check_outs();
    endtask

    // Main sequence: reset values, all-ones writes, partial strobes, random traffic, reset.
    initial begin
        int i;
        int idx;
        seed = 32'hbcdcee54;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        err_count = 0;
        compares = 0;
        m_en = 7'h0;
        m_egr = 8'h0;
        m_lat = 32'h0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (i = 0; i < 9; i++) apb(1'b0, tab[i], 32'h0, 4'h0);
        // Back-to-back writes of all ones probe read-only and reserved bits.
        for (i = 0; i < 9; i++) apb(1'b1, tab[i], 32'hFFFF_FFFF, 4'hF);
        for (i = 0; i < 9; i++) apb(1'b0, tab[i], 32'h0, 4'h0);
        apb(1'b1, 12'h234, 32'h0000_0000, 4'h5);
        apb(1'b0, 12'h234, 32'h0, 4'h0);
        apb(1'b1, 12'h224, 32'h0055_0000, 4'h3);
        apb(1'b0, 12'h224, 32'h0, 4'h0);
        idle();
        // Random traffic, sometimes chained and sometimes with gaps.
        repeat (120) begin
            idx = {$random(seed)} % 9;
            apb(1'($random(seed)), tab[idx], $random(seed), 4'($random(seed)));
            if ($random(seed) & 1) idle();
        end
        idle();
        // A second reset in mid-run must clear every writable field.
        rst <= 1'b1;
        m_en = 7'h0;
        m_egr = 8'h0;
        m_lat = 32'h0;
        repeat (3) @(posedge core_clk);
        check_outs();
        rst <= 1'b0;
        @(posedge core_clk);
        for (i = 0; i < 9; i++) apb(1'b0, tab[i], 32'h0, 4'h0);
        idle();
        close_out();
    end
endmodule
`default_nettype wire
